/* File: src/kgp_ports.v */
// Contract
// [RULE1] direction bit 1 output, 0 input
// [RULE2] direction registers are write-only
// [RULE3] data read: output latch or pad level
// [RULE4] pull-up on when disable bit 0, input
// [RULE5] pull-ups off on output pins
// [RULE6] output data 0 drives pad low
// [RULE7] output data 1 releases pad
// [RULE8] reset clears data registers
// [RULE9] reset clears direction, pins inputs
// [RULE10] reset clears pull-up disable bits
// [RULE11] ports d, e use bits 3:0
// [RULE12] port f uses bits 7:0
// [RULE13] port c write-only 8-bit pull-up disable
// [RULE14] port d direction 7:4 read zero
// [RULE15] small package: leave e upper bits reset
// [RULE16] port c pins open-drain
// [RULE17] rising-edge option forces c pull-ups off
// [RULE18] reserved bits read 0, writes ignored
// [RULE19] pad inputs double synchronised
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "kgp_map.vh"

module kgp_ports (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [9:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [7:0]  port_c_dir_i,
  input  wire [3:0]  port_d_pad_i,
  input  wire [3:0]  port_e_pad_i,
  input  wire [7:0]  port_f_pad_i,
  output reg  [3:0]  port_d_pad_o,
  output reg  [3:0]  port_d_pad_oe_o,
  output reg  [3:0]  port_e_pad_o,
  output reg  [3:0]  port_e_pad_oe_o,
  output reg  [7:0]  port_f_pad_o,
  output reg  [7:0]  port_f_pad_oe_o,
  output reg  [7:0]  port_c_pullup_en_o,
  output reg  [3:0]  port_d_pullup_en_o,
  output reg  [3:0]  port_e_pullup_en_o,
  output reg  [7:0]  port_f_pullup_en_o
);

  reg  [7:0]  port_c_pullup_off_bits;
  reg  [3:0]  port_d_data_bits;
  reg  [3:0]  port_d_direction_bits;
  reg  [3:0]  port_d_pullup_off_bits;
  reg  [3:0]  port_e_data_bits;
  reg  [3:0]  port_e_direction_bits;
  reg  [3:0]  port_e_pullup_off_bits;
  reg  [7:0]  port_f_data_bits;
  reg  [7:0]  port_f_direction_bits;
  reg  [7:0]  port_f_pullup_off_bits;
  reg  [1:0]  c_option_r;
  reg  [15:0] pad_meta_r;
  reg  [15:0] pad_sync_r;
  reg  [31:0] rd_nxt;
  wire [7:0]  idx;
  wire        wr_en;
  wire        req;
  wire [3:0]  d_lvl;
  wire [3:0]  e_lvl;
  wire [7:0]  f_lvl;
  wire        c_force_off;

  // word-aligned index; only byte lane 0 carries register data
  assign idx   = wb_adr_i[9:2];
  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = req & wb_we_i & wb_sel_i[0];

  // two-flop synchroniser; first stage read only by the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      pad_meta_r <= 16'h0000;
      pad_sync_r <= 16'h0000;
    end else begin
      pad_meta_r <= {port_f_pad_i, port_e_pad_i, port_d_pad_i}; // [RULE19]
      pad_sync_r <= pad_meta_r;
    end
  end

  assign d_lvl = pad_sync_r[3:0];
  assign e_lvl = pad_sync_r[7:4];
  assign f_lvl = pad_sync_r[15:8];

  // register writes land on the acknowledging edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_c_pullup_off_bits <= `KGP_RST_8; // [RULE10]
      port_d_data_bits       <= `KGP_RST_4; // [RULE8]
      port_d_direction_bits  <= `KGP_RST_4; // [RULE9]
      port_d_pullup_off_bits <= `KGP_RST_4;
      port_e_data_bits       <= `KGP_RST_4;
      port_e_direction_bits  <= `KGP_RST_4;
      port_e_pullup_off_bits <= `KGP_RST_4;
      port_f_data_bits       <= `KGP_RST_8;
      port_f_direction_bits  <= `KGP_RST_8;
      port_f_pullup_off_bits <= `KGP_RST_8;
      c_option_r             <= 2'h0;
    end else if (wr_en) begin
      // upper bits of narrow ports are dropped on write
      case (idx)
        `KGP_IDX_C_PULLUP: port_c_pullup_off_bits <= wb_dat_i[7:0]; // [RULE13]
        `KGP_IDX_D_DIR:    port_d_direction_bits  <= wb_dat_i[3:0]; // [RULE11]
        `KGP_IDX_D_DATA:   port_d_data_bits       <= wb_dat_i[3:0]; // [RULE18]
        `KGP_IDX_D_PULLUP: port_d_pullup_off_bits <= wb_dat_i[3:0];
        `KGP_IDX_E_DIR:    port_e_direction_bits  <= wb_dat_i[3:0];
        `KGP_IDX_E_DATA:   port_e_data_bits       <= wb_dat_i[3:0];
        `KGP_IDX_E_PULLUP: port_e_pullup_off_bits <= wb_dat_i[3:0];
        `KGP_IDX_F_DIR:    port_f_direction_bits  <= wb_dat_i[7:0]; // [RULE12]
        `KGP_IDX_F_DATA:   port_f_data_bits       <= wb_dat_i[7:0];
        `KGP_IDX_F_PULLUP: port_f_pullup_off_bits <= wb_dat_i[7:0];
        `KGP_IDX_C_OPTION: c_option_r             <= wb_dat_i[1:0];
        default: ;
      endcase
    end
  end

  // read mux; write-only registers and unmapped words read zero
  always @* begin
    rd_nxt = 32'h0000_0000; // [RULE2]
    case (idx)
      // d direction upper nibble belongs to reset logic, zero here
      `KGP_IDX_D_DIR:    rd_nxt = 32'h0000_0000; // [RULE14]
      `KGP_IDX_D_DATA:
        rd_nxt[3:0] = (port_d_direction_bits & port_d_data_bits) |
                      (~port_d_direction_bits & d_lvl); // [RULE3]
      `KGP_IDX_E_DATA:
        rd_nxt[3:0] = (port_e_direction_bits & port_e_data_bits) |
                      (~port_e_direction_bits & e_lvl);
      `KGP_IDX_F_DATA:
        rd_nxt[7:0] = (port_f_direction_bits & port_f_data_bits) |
                      (~port_f_direction_bits & f_lvl);
      `KGP_IDX_C_OPTION: rd_nxt[1:0] = c_option_r;
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end

  // single-wait-state slave: ack one cycle after the request, then drop
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_nxt : 32'h0000_0000;
    end
  end

  assign c_force_off = c_option_r[`KGP_OPT_AIPC_BIT] & c_option_r[`KGP_OPT_IPPC_BIT];

  // open-drain pads: out value is always 0, enable sinks the pad
  always @(posedge clk_i) begin
    if (rst_i) begin
      port_d_pad_o       <= 4'h0;
      port_d_pad_oe_o    <= 4'h0;
      port_e_pad_o       <= 4'h0;
      port_e_pad_oe_o    <= 4'h0;
      port_f_pad_o       <= 8'h00;
      port_f_pad_oe_o    <= 8'h00;
      port_c_pullup_en_o <= 8'hff;
      port_d_pullup_en_o <= 4'hf;
      port_e_pullup_en_o <= 4'hf;
      port_f_pullup_en_o <= 8'hff;
    end else begin
      port_d_pad_o       <= 4'h0;
      port_e_pad_o       <= 4'h0;
      port_f_pad_o       <= 8'h00;
      port_d_pad_oe_o    <= port_d_direction_bits & ~port_d_data_bits; // [RULE1] [RULE6] [RULE7]
      port_e_pad_oe_o    <= port_e_direction_bits & ~port_e_data_bits;
      port_f_pad_oe_o    <= port_f_direction_bits & ~port_f_data_bits;
      // port c direction lives elsewhere and arrives as a level
      port_c_pullup_en_o <= ~port_c_pullup_off_bits & ~port_c_dir_i &
                            {8{~c_force_off}}; // [RULE16] [RULE17]
      port_d_pullup_en_o <= ~port_d_pullup_off_bits & ~port_d_direction_bits; // [RULE4] [RULE5]
      port_e_pullup_en_o <= ~port_e_pullup_off_bits & ~port_e_direction_bits;
      port_f_pullup_en_o <= ~port_f_pullup_off_bits & ~port_f_direction_bits;
    end
  end

endmodule // kgp_ports

/* File: src/kgp_map.vh */
`ifndef KGP_MAP_VH
`define KGP_MAP_VH
// register indices; byte address is four times the index
`define KGP_IDX_C_PULLUP   8'h0b
`define KGP_IDX_D_DIR      8'h11
`define KGP_IDX_D_DATA     8'h12
`define KGP_IDX_D_PULLUP   8'h13
`define KGP_IDX_E_DIR      8'h14
`define KGP_IDX_E_DATA     8'h15
`define KGP_IDX_E_PULLUP   8'h16
`define KGP_IDX_F_DIR      8'h17
`define KGP_IDX_F_DATA     8'h18
`define KGP_IDX_F_PULLUP   8'h19
// control register for the port c interrupt polarity option
`define KGP_IDX_C_OPTION   8'h20
`define KGP_OPT_AIPC_BIT   0
`define KGP_OPT_IPPC_BIT   1
// reset values
`define KGP_RST_4          4'h0
`define KGP_RST_8          8'h00
`endif

/* File: tb/kgp_ports_chk.sv */
`timescale 1ns/1ps
// protocol and pad relations seen only at the block's ports
module kgp_ports_chk (
  input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [7:0]  port_c_dir_i, port_c_pullup_en_o, port_f_pad_o,
  input wire logic [7:0]  port_f_pad_oe_o, port_f_pullup_en_o,
  input wire logic [3:0]  port_d_pad_o, port_e_pad_o, port_d_pad_oe_o, port_d_pullup_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_answer:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_idle_dat:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  a_dat_upper:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  a_wo_read:
    assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[9:2]) inside
      {8'h0b, 8'h11, 8'h13, 8'h14, 8'h16, 8'h17, 8'h19} |-> wb_dat_o == 32'h0)
      else $error("write-only register read nonzero");
  a_never_high:
    assert property ({port_d_pad_o, port_e_pad_o, port_f_pad_o} == 16'h0)
      else $error("pad driven high");
  a_reset_state:
    assert property ($past(rst_i) |-> port_f_pad_oe_o == 8'h0 && port_f_pullup_en_o == 8'hff)
      else $error("wrong state after reset");
  a_out_no_pull:
    assert property ((port_f_pad_oe_o & port_f_pullup_en_o) == 8'h0
      && (port_d_pad_oe_o & port_d_pullup_en_o) == 4'h0) else $error("pull-up on sinking pin");
  a_c_out_pull:
    assert property (!$past(rst_i) |-> ($past(port_c_dir_i) & port_c_pullup_en_o) == 8'h0)
      else $error("port c output with pull-up");
  c_write: cover property (wb_ack_o && $past(wb_we_i));
  c_f_sink: cover property (port_f_pad_oe_o != 8'h0);
  c_c_off: cover property (port_c_pullup_en_o == 8'h0);
endmodule // kgp_ports_chk
bind kgp_ports kgp_ports_chk chk_u (.*);

/* File: tb/kgp_pads.sv */
`timescale 1ns/1ps
// pads: sink wins, then outside drive, then pull-up; a bare pad wanders
module kgp_pads #(parameter int W = 16) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] oe_i, pu_i, ext_en_i, ext_i,
  output logic      [W-1:0] lvl_o
);
  logic [W-1:0] flt_r = '0;
  always @(posedge clk_i) flt_r <= ~flt_r;  // no stale level to lean on
  assign lvl_o = ~oe_i & ((ext_en_i & ext_i) | (~ext_en_i & (pu_i | flt_r)));
endmodule // kgp_pads

/* File: tb/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack;
  logic [9:0] adr = 0;
  logic [31:0] wdat = 0, rdat, seed = 32'h94a87af4, r, r2;
  logic [15:0] oe16, pu16, lvl, een = 0, ext = 0, dir = 0, dat = 0, dis = 0, q;
  logic [7:0] cdir = 0, cdis = 0, cpu;
  logic [1:0] opt = 0;
  int n_checks = 0, num_errors = 0;
  logic [15:0] exp_q[$];
  wire [3:0] dpad, epad;
  wire [7:0] fpad;
  always #12.5 clk_i = ~clk_i;
  kgp_ports dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_c_dir_i(cdir), .port_d_pad_i(lvl[3:0]), .port_e_pad_i(lvl[7:4]),
    .port_f_pad_i(lvl[15:8]), .port_d_pad_o(), .port_e_pad_o(), .port_f_pad_o(),
    .port_d_pad_oe_o(oe16[3:0]), .port_e_pad_oe_o(oe16[7:4]), .port_f_pad_oe_o(oe16[15:8]),
    .port_c_pullup_en_o(cpu), .port_d_pullup_en_o(pu16[3:0]),
    .port_e_pullup_en_o(pu16[7:4]), .port_f_pullup_en_o(pu16[15:8]));
  kgp_pads #(.W(16)) pads_u (.clk_i, .oe_i(oe16), .pu_i(pu16), .ext_en_i(een), .ext_i(ext),
    .lvl_o(lvl));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] sel(logic [15:0] v, int p);
    return p == 2 ? v[15:8] : {4'h0, p == 1 ? v[7:4] : v[3:0]};
  endfunction
  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one classic cycle; read expectations go on the queue with a mask
  task automatic bus(logic w, logic [7:0] idx, d, m, e);
    int n = 0;
    if (!w) exp_q.push_back({m, e});
    cyc <= 1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 40);
    if (n == 40) begin num_errors++; complete_run(); end
    cyc <= 0; we <= 0;
    @(posedge clk_i);
  endtask
  // read data watcher, takes the oldest note per ack
  always @(posedge clk_i) if (ack === 1'b1 && !we) begin
    q = exp_q.pop_front();
    `CHK(rdat[7:0] & q[15:8], q[7:0])
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (int k = 0; k < 40; k++) begin
      if (k > 0) begin  // pass 0 sees reset state only
        // only four e pins modelled; upper e bits are reserved and only take junk writes
        r = rnd(); dir = r[15:0]; dat = r[31:16]; r2 = rnd(); een <= r2[15:0]; ext <= r2[31:16];
        r = rnd(); dis = r[15:0] & r2[15:0]; cdis = r[23:16]; cdir <= r[31:24]; opt = r[1:0];
        for (int p = 0; p < 3; p++) begin  // junk in port e reserved bits
          bus(1, 8'(8'h11 + 3 * p), sel(dir, p) | (p == 1 ? r[7:4] << 4 : 8'h0), 0, 0);
          bus(1, 8'(8'h12 + 3 * p), sel(dat, p), 0, 0);
          bus(1, 8'(8'h13 + 3 * p), sel(dis, p), 0, 0);
        end
        bus(1, 8'h0b, cdis, 0, 0);
        bus(1, 8'h20, {6'h0, opt}, 0, 0);
        bus(1, 8'h3f, r[7:0], 0, 0);
      end
      // outputs have stood for cycles, so sampling at the edge is safe
      repeat (3) @(posedge clk_i);
      `CHK({oe16, pu16}, {dir & ~dat, ~dir & ~dis})
      `CHK(cpu, &opt ? 8'h0 : ~cdir & ~cdis)
      for (int p = 0; p < 3; p++) begin
        bus(0, 8'(8'h11 + 3 * p), 0, 8'hff, 0);
        bus(0, 8'(8'h12 + 3 * p), 0, p == 0 ? 8'h0f : 8'hff,
          sel((dir & dat) | (~dir & ((een & ext) | ~een)), p));
        bus(0, 8'(8'h13 + 3 * p), 0, 8'hff, 0);
      end
      bus(0, 8'h0b, 0, 8'hff, 0);
      bus(0, 8'h20, 0, 8'hff, {6'h0, opt});
      bus(0, 8'h3f, 0, 8'hff, 0);
    end
    complete_run();
  end
endmodule // tb
